// >>> i2csw_switch.sv
// Two-channel bus switch: slave controller, channel select and interrupt combiner
`timescale 1ns/1ps
`default_nettype none
`include "i2csw_cfg.svh"

module i2csw_switch
   import i2csw_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Upstream bus pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe_n,
   // Address strap
   input  wire logic addr_select_pin,
   // Downstream channel connects
   output var  logic downstream_bus_ch0_connect,
   output var  logic downstream_bus_ch1_connect,
   // Interrupts
   input  wire logic irq_in_ch0_n,
   input  wire logic irq_in_ch1_n,
   output var  logic irq_out_n
);

   // Two-stage synchronisers, third stage on scl and sda for edge detection
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] a0_sync;
   logic [1:0] irq0_sync;
   logic [1:0] irq1_sync;
   logic       scl_prev;
   logic       sda_prev;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sync  <= 2'h3;
         sda_sync  <= 2'h3;
         a0_sync   <= 2'h0;
         irq0_sync <= 2'h3;
         irq1_sync <= 2'h3;
         scl_prev  <= 1'b1;
         sda_prev  <= 1'b1;
      end else begin
         scl_sync  <= {scl_sync[0], scl_in};
         sda_sync  <= {sda_sync[0], sda_in};
         a0_sync   <= {a0_sync[0], addr_select_pin};
         irq0_sync <= {irq0_sync[0], irq_in_ch0_n};
         irq1_sync <= {irq1_sync[0], irq_in_ch1_n};
         scl_prev  <= scl_sync[1];
         sda_prev  <= sda_sync[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [1:0] irq_active;

   always_comb begin
      scl_s      = scl_sync[1];
      sda_s      = sda_sync[1];
      scl_rise   = scl_s & ~scl_prev;
      scl_fall   = ~scl_s & scl_prev;
      start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
      stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;
      irq_active = {~irq1_sync[1], ~irq0_sync[1]};
   end

   // Controller state
   i2csw_state_t state;
   i2csw_state_t next_state;
   logic [3:0]   bit_cnt;
   logic [3:0]   next_bit_cnt;
   logic [7:0]   shift;
   logic [7:0]   next_shift;
   logic         rw;
   logic         next_rw;
   logic         master_ack;
   logic         next_master_ack;
   logic         drive_low;
   logic         next_drive_low;
   logic [1:0]   sel;
   logic [1:0]   next_sel;
   logic [1:0]   pend_sel;
   logic [1:0]   next_pend_sel;
   logic         pend_valid;
   logic         next_pend_valid;
   logic [7:0]   ctrl_byte;

   // Interrupt bits 5:4 are live pin state, never stored from a write
   always_comb begin
      ctrl_byte = 8'h00;
      ctrl_byte[`I2CSW_IRQ_LSB +: 2] = irq_active;
      ctrl_byte[`I2CSW_SEL_LSB +: `I2CSW_SEL_W] = sel;
   end

   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_rw         = rw;
      next_master_ack = master_ack;
      next_drive_low  = drive_low;
      next_sel        = sel;
      next_pend_sel   = pend_sel;
      next_pend_valid = pend_valid;
      if (stop_seen) begin
         next_state     = I2CSW_IDLE;
         next_drive_low = 1'b0;
         if (pend_valid) begin
            next_sel        = pend_sel;
            next_pend_valid = 1'b0;
         end
      end else if (start_seen) begin
         // Repeated start drops any pending write that has no STOP yet
         next_state      = I2CSW_ADDR;
         next_bit_cnt    = 4'h0;
         next_drive_low  = 1'b0;
         next_pend_valid = 1'b0;
      end else if (scl_rise) begin
         unique case (state)
            I2CSW_ADDR, I2CSW_WR_DATA: begin
               next_shift   = {shift[6:0], sda_s};
               next_bit_cnt = bit_cnt + 4'h1;
            end
            I2CSW_RD_DATA: next_bit_cnt = bit_cnt + 4'h1;
            I2CSW_RD_ACK:  next_master_ack = ~sda_s;
            I2CSW_IDLE, I2CSW_ADDR_ACK, I2CSW_WR_ACK: ;
         endcase
      end else if (scl_fall) begin
         unique case (state)
            I2CSW_ADDR: begin
               if (bit_cnt == `I2CSW_BITS_BYTE) begin
                  if (shift[7:1] == {`I2CSW_ADDR_HI, a0_sync[1]}) begin
                     next_rw        = shift[0];
                     next_drive_low = 1'b1;
                     next_state     = I2CSW_ADDR_ACK;
                  end else begin
                     next_state = I2CSW_IDLE;
                  end
               end
            end
            I2CSW_ADDR_ACK: begin
               next_bit_cnt = 4'h0;
               if (rw) begin
                  next_shift     = {ctrl_byte[6:0], 1'b0};
                  next_drive_low = ~ctrl_byte[7];
                  next_state     = I2CSW_RD_DATA;
               end else begin
                  next_drive_low = 1'b0;
                  next_state     = I2CSW_WR_DATA;
               end
            end
            I2CSW_WR_DATA: begin
               if (bit_cnt == `I2CSW_BITS_BYTE) begin
                  // Held until STOP, so the bus is not switched mid-transfer
                  next_pend_sel   = shift[`I2CSW_SEL_LSB +: `I2CSW_SEL_W];
                  next_pend_valid = 1'b1;
                  next_drive_low  = 1'b1;
                  next_state      = I2CSW_WR_ACK;
               end
            end
            I2CSW_WR_ACK: begin
               next_drive_low = 1'b0;
               next_bit_cnt   = 4'h0;
               next_state     = I2CSW_WR_DATA;
            end
            I2CSW_RD_DATA: begin
               if (bit_cnt == `I2CSW_BITS_BYTE) begin
                  next_drive_low = 1'b0;
                  next_state     = I2CSW_RD_ACK;
               end else begin
                  next_drive_low = ~shift[7];
                  next_shift     = {shift[6:0], 1'b0};
               end
            end
            I2CSW_RD_ACK: begin
               next_bit_cnt = 4'h0;
               if (master_ack) begin
                  next_shift     = {ctrl_byte[6:0], 1'b0};
                  next_drive_low = ~ctrl_byte[7];
                  next_state     = I2CSW_RD_DATA;
               end else begin
                  next_state = I2CSW_IDLE;
               end
            end
            I2CSW_IDLE: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state      <= I2CSW_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         rw         <= 1'b0;
         master_ack <= 1'b0;
         drive_low  <= 1'b0;
         sel        <= `I2CSW_SEL_RESET;
         pend_sel   <= `I2CSW_SEL_RESET;
         pend_valid <= 1'b0;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         rw         <= next_rw;
         master_ack <= next_master_ack;
         drive_low  <= next_drive_low;
         sel        <= next_sel;
         pend_sel   <= next_pend_sel;
         pend_valid <= next_pend_valid;
      end
   end

   // Output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out                    <= 1'b0;
         sda_oe_n                   <= 1'b1;
         downstream_bus_ch0_connect <= 1'b0;
         downstream_bus_ch1_connect <= 1'b0;
         irq_out_n                  <= 1'b1;
      end else begin
         sda_out                    <= 1'b0;
         sda_oe_n                   <= ~next_drive_low;
         downstream_bus_ch0_connect <= next_sel[0];
         downstream_bus_ch1_connect <= next_sel[1];
         irq_out_n                  <= irq0_sync[1] & irq1_sync[1];
      end
   end

endmodule
`default_nettype wire

// >>> i2csw_cfg.svh
// Constants for the two-channel bus switch
`ifndef I2CSW_CFG_SVH
`define I2CSW_CFG_SVH

// Upper six bits of the 7-bit slave address; the low bit follows addr_select_pin
`define I2CSW_ADDR_HI      6'h39
// Control byte layout
`define I2CSW_SEL_LSB      0
`define I2CSW_SEL_W        2
`define I2CSW_IRQ_LSB      4
`define I2CSW_SEL_RESET    2'h0
`define I2CSW_SEL_CH0      2'h1
`define I2CSW_SEL_CH1      2'h2
`define I2CSW_SEL_BOTH     2'h3
`define I2CSW_BITS_BYTE    4'h8

`endif

// >>> i2csw_pkg.sv
// Types for the two-channel bus switch
package i2csw_pkg;
   typedef enum logic [2:0] {
      I2CSW_IDLE     = 3'b000,
      I2CSW_ADDR     = 3'b001,
      I2CSW_ADDR_ACK = 3'b010,
      I2CSW_WR_DATA  = 3'b011,
      I2CSW_WR_ACK   = 3'b100,
      I2CSW_RD_DATA  = 3'b101,
      I2CSW_RD_ACK   = 3'b110
   } i2csw_state_t;
endpackage

// >>> i2csw_asserts.sv
// Checker on the bus switch ports
`timescale 1ns/1ps
`default_nettype none
module i2csw_asserts (
   // Watched ports
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_n,
   input wire logic downstream_bus_ch0_connect,
   input wire logic downstream_bus_ch1_connect,
   input wire logic irq_in_ch0_n,
   input wire logic irq_in_ch1_n,
   input wire logic irq_out_n
);
   wire  [1:0] conn = {downstream_bus_ch1_connect, downstream_bus_ch0_connect};
   logic [3:0] since;
   logic       sda_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since a stop on the raw pins, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_q <= 1'h1;
         since <= 4'hF;
      end else begin
         sda_q <= sda_in;
         since <= (scl_in && sda_in && !sda_q) ? 4'h0 : since + {3'h0, since != 4'hF};
      end
   end
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence
   AST_RST_IDLE: assert property ($fell(rst) |-> conn == 2'h0)
      else $error("channel joined after reset");
   AST_STOP_ONLY: assert property ($changed(conn) |-> since < 4'hC)
      else $error("select moved without stop");
   AST_FRAME_HOLD: assert property (s_start |=> $stable(conn) [*8])
      else $error("select moved in frame");
   AST_IRQ_LOW: assert property ((!irq_in_ch0_n || !irq_in_ch1_n) [*4] |-> !irq_out_n)
      else $error("irq out not low");
   AST_IRQ_HIGH: assert property ((irq_in_ch0_n && irq_in_ch1_n) [*4] |-> irq_out_n)
      else $error("irq out not high");
   AST_IRQ_ROSE: assert property ($rose(irq_out_n) |-> $past(irq_in_ch0_n, 3) && $past(irq_in_ch1_n, 3))
      else $error("irq out rose early");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("sda moved with scl high");
   AST_OE_HOLD: assert property ($fell(sda_oe_n) |-> (!sda_oe_n) [*8])
      else $error("sda pull too short");
endmodule
bind i2csw_switch i2csw_asserts u_chk (.clk, .rst, .scl_in, .sda_in, .sda_oe_n, .downstream_bus_ch0_connect,
   .downstream_bus_ch1_connect, .irq_in_ch0_n, .irq_in_ch1_n, .irq_out_n);
`default_nettype wire

// >>> i2csw_master.sv
// Upstream bus master model
`timescale 1ns/1ps
`default_nettype none
module i2csw_master (
   // Clock and wired data level
   input  wire logic clk,
   input  wire logic sda,
   // Driven lines, sda_rel high lets the pull-up win
   output var  logic scl,
   output var  logic sda_rel
);
   initial begin
      scl = 1'h1;
      sda_rel = 1'h1;
   end
   // Ten cycles a phase keeps the oversampler's margin
   task automatic hp();
      repeat (10) @(posedge clk);
   endtask
   task automatic start();
      sda_rel <= 1'h0;
      hp();
      scl <= 1'h0;
      hp();
   endtask
   task automatic stop();
      sda_rel <= 1'h0;
      hp();
      scl <= 1'h1;
      hp();
      sda_rel <= 1'h1;
      hp();
   endtask
   // Repeated start from the low phase that ends a byte, no stop in between
   task automatic restart();
      sda_rel <= 1'h1;
      hp();
      scl <= 1'h1;
      hp();
      start();
   endtask
   // MSB first; SDA only moves while SCL is low
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sda_rel <= (i > 0) ? tx[i-1] : ack_in;
         hp();
         scl <= 1'h1;
         hp();
         if (i > 0) rx[i-1] = sda;
         else ack = sda;
         scl <= 1'h0;
         hp();
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Random self-checking bench for the bus switch
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk, rst, a0, i0, i1, scl, rel, oe_n, sd_o, c0, c1, io_n, ack, aack;
   logic [1:0] sel, prev;
   logic [7:0] rx, d;
   int         fails = 0, tests_run = 0, seed, cyc = 0;
   wire        sda = rel & (oe_n | sd_o);
   wire  [7:0] conn = {6'h00, c1, c0};
   i2csw_switch u_dut (.clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out(sd_o), .sda_oe_n(oe_n),
      .addr_select_pin(a0), .downstream_bus_ch0_connect(c0), .downstream_bus_ch1_connect(c1),
      .irq_in_ch0_n(i0), .irq_in_ch1_n(i1), .irq_out_n(io_n));
   i2csw_master u_mst (.clk, .sda, .scl, .sda_rel(rel));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] exp_byte(input logic [1:0] s, input logic n0, input logic n1);
      return {2'h0, ~n1, ~n0, 2'h0, s};
   endfunction
   // One-byte write; the select must not move before the stop
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      u_mst.start();
      u_mst.xfer(adr, 1'h1, rx, aack);
      u_mst.xfer(dat, 1'h1, rx, ack);
      chk("conn before stop", 8'(prev), conn);
      u_mst.stop();
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      seed = 7;
      rst = 1'h1;
      a0 = 1'h0;
      i0 = 1'h1;
      i1 = 1'h1;
      prev = 2'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      chk("conn after reset", 8'h00, conn);
      for (int k = 0; k < 6; k++) begin
         sel = (k < 4) ? 2'(k) : 2'($random(seed));
         d = 8'($random(seed));
         d[1:0] = sel;
         i0 <= 1'($random(seed));
         i1 <= 1'($random(seed));
         wr(8'hE4, d);
         chk("address ack", 8'h00, 8'(aack));
         chk("conn after stop", 8'(sel), conn);
         u_mst.start();
         u_mst.xfer(8'hE5, 1'h1, rx, aack);
         u_mst.xfer(8'hFF, 1'h1, rx, ack);
         u_mst.stop();
         chk("read address ack", 8'h00, 8'(aack));
         chk("control byte", exp_byte(sel, i0, i1), rx);
         chk("sda out level", 8'h00, 8'(sd_o));
         chk("irq out", 8'(i0 & i1), 8'(io_n));
         prev = sel;
         $display("test %0d done", k);
      end
      // Write cut by a repeated start must never reach the channels
      u_mst.start();
      u_mst.xfer(8'hE4, 1'h1, rx, aack);
      u_mst.xfer({6'h00, ~prev}, 1'h1, rx, ack);
      u_mst.restart();
      u_mst.xfer(8'hE5, 1'h1, rx, aack);
      u_mst.xfer(8'hFF, 1'h1, rx, ack);
      u_mst.stop();
      chk("select after restart", 8'(prev), 8'(rx[1:0]));
      chk("conn after restart", 8'(prev), conn);
      $display("restart test done");
      wr(8'hE6, 8'h00);
      chk("foreign address ack", 8'h01, 8'(aack));
      a0 <= 1'h1;
      wr(8'hE6, 8'h03);
      chk("strapped address ack", 8'h00, 8'(aack));
      chk("strapped conn", 8'h03, conn);
      // Idle-high interrupts so the released synchronisers fill with no false edge
      i0 <= 1'h1;
      i1 <= 1'h1;
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      chk("conn in reset", 8'h00, conn);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      prev = 2'h0;
      wr(8'hE6, 8'h02);
      chk("conn after second reset", 8'h02, conn);
      $display("address and reset test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
